// ---- hdl/ccsr_pkg.sv ----
package ccsr_pkg;

    // Control word field positions.
    localparam int CTL_RST_BIT = 15;
    localparam int CTL_MATCH_LSB = 13;
    localparam int CTL_FULL_LSB = 11;
    localparam int CTL_XLATE_LSB = 9;
    localparam int CTL_PART_LSB = 6;
    localparam int CTL_MASK_LSB = 4;
    localparam int CTL_STEP_LSB = 2;
    localparam int CTL_MODE_LSB = 0;

    // Segment control word field positions.
    localparam int SEG_DLIM_STB = 15;
    localparam int SEG_DSTART_LSB = 13;
    localparam int SEG_DEND_LSB = 11;
    localparam int SEG_SLIM_STB = 10;
    localparam int SEG_SSTART_LSB = 8;
    localparam int SEG_SEND_LSB = 6;
    localparam int SEG_DCNT_STB = 5;
    localparam int SEG_DCNT_LSB = 3;
    localparam int SEG_SCNT_STB = 2;
    localparam int SEG_SCNT_LSB = 0;

    // Two-bit field codes.
    localparam logic [1:0] FLD_KEEP = 2'h3;
    localparam logic [1:0] FLD_RSVD = 2'h2;
    localparam logic [1:0] STEP_INC = 2'h0;
    localparam logic [1:0] STEP_DEC = 2'h1;
    localparam logic [1:0] MASK_NONE = 2'h0;
    localparam logic [1:0] MASK_FIRST = 2'h1;
    localparam logic [1:0] MASK_SECOND = 2'h2;

    // Validity states of a memory location.
    localparam logic [1:0] VB_VALID = 2'h0;
    localparam logic [1:0] VB_EMPTY = 2'h1;
    localparam logic [1:0] VB_SKIP = 2'h2;
    localparam logic [1:0] VB_RAM = 2'h3;

    // Reset values.
    localparam logic [1:0] RST_FLAG_DIS = 2'h0;
    localparam logic [2:0] RST_PART = 3'h0;
    localparam logic [1:0] RST_SEG_START = 2'h0;
    localparam logic [1:0] RST_SEG_END = 2'h3;
    localparam logic [3:0] RST_PSRC = 4'h0;

    // Instruction classes (upper byte) and select targets (low nibble).
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_SELECT = 8'h02;
    localparam logic [7:0] OPC_STORE = 8'h03;
    localparam logic [7:0] OPC_SETVB = 8'h04;
    localparam logic [7:0] OPC_COMPARE = 8'h05;
    localparam logic [7:0] OPC_SETPS = 8'h06;
    localparam logic [3:0] TGT_CTL = 4'h0;
    localparam logic [3:0] TGT_SEG = 4'h1;
    localparam logic [3:0] TGT_NFREE = 4'h2;
    localparam logic [3:0] TGT_STATUS = 4'h3;
    localparam logic [3:0] TGT_IDSRC = 4'h4;
    localparam logic [3:0] TGT_CMP = 4'h5;
    localparam logic [3:0] TGT_MASK1 = 4'h6;
    localparam logic [3:0] TGT_MASK2 = 4'h7;

    // Readout selection for the next Command Read.
    typedef enum logic [2:0] {
        RD_STAT_LO = 3'h0,
        RD_STAT_HI = 3'h1,
        RD_NFREE = 3'h2,
        RD_IDSRC = 3'h3,
        RD_CTL = 3'h4,
        RD_SEG = 3'h5
    } ccsr_rdsel_t;

    // Compare scan states, Gray along idle, run, last.
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_RUN = 2'b01,
        SCAN_LAST = 2'b11
    } ccsr_scan_t;

endpackage : ccsr_pkg

// ---- hdl/ccsr_word_mem.sv ----
module ccsr_word_mem #(
    parameter int DW = 64,
    parameter int DEPTH = 4096,
    parameter int AW = 12
) (
    input wire logic core_clk,
    input wire logic [AW-1:0] wrAddr,
    input wire logic wrDataEn,
    input wire logic [DW-1:0] wrData,
    input wire logic wrVbEn,
    input wire logic [1:0] wrVb,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData,
    output logic [1:0] rdVb
);

    logic [DW-1:0] wordMem [DEPTH];
    logic [1:0] vbMem [DEPTH];

    // Validity lives apart from data so that a state change keeps the word.
    always_ff @(posedge core_clk) begin
        if (wrDataEn) begin
            wordMem[wrAddr] <= wrData;
        end
        rdData <= wordMem[rdAddr];
    end

    always_ff @(posedge core_clk) begin
        if (wrVbEn) begin
            vbMem[wrAddr] <= wrVb;
        end
        rdVb <= vbMem[rdAddr];
    end

endmodule : ccsr_word_mem

// ---- hdl/ccsr_regs.sv ----
// Operation
// - Control bit 15 written 0 resets the device; it reads back 0.
// - Control 14:13 match flag: 00 enable, 01 disable, 11 keep.
// - Control 12:11 full flag: 00 enable, 01 disable, 11 keep.
// - Control 10:9 translation: 00 off, 01 on, 11 keep.
// - Control 3:2 pointer step: increment, decrement, disable, 11 keep.
// - Control 1:0 mode: 00 standard, 01 enhanced, 11 keep.
// - Segment bit 15 low loads destination limits from 14:13, 12:11.
// - Segment bit 10 low loads source limits from 9:8, 7:6.
// - Segment bit 5 low loads destination count from 4:3.
// - Segment bit 2 low loads source count from 1:0.
// - Segment bits 15, 10, 5 and 2 read back 0.
// - Next-free word read by one Command Read after its select.
// - Next-free word: free location low, page number above.
// - Status read low half first, high half on next Command Read.
// - Status 31 low when full, 30 low on multiple match.
// - Status 29:28 give validity state of reported location.
// - Status match location from bit 1, page above, rest zero.
// - Status bit 0 is the active-low match flag.
// - Identity word read after its select; bits 3:0 source setting.
// - Identity word bits 15:4 hold the part identity code.
// - Locations hold validity; only valid ones take part in compare.
module ccsr_regs #(
    parameter int DEPTH = 4096,
    parameter logic [15:0] PAGE_NUM = 16'h0000,
    // Identity value is arbitrary.
    parameter logic [11:0] PART_ID = 12'h5a3
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chipEnN,
    input wire logic cmdSelN,
    input wire logic writeN,
    input wire logic [15:0] dqIn,
    output logic [15:0] dqOut,
    output logic dqOe,
    output logic matchFlagN,
    output logic multiMatchFlagN,
    output logic fullFlagN,
    output logic translateOn,
    output logic enhancedMode
);

    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and host cycle decode.

    logic [18:0] pinMeta_reg;
    logic [18:0] pinSync_reg;
    logic enPrev_reg;
    always_ff @(posedge core_clk) begin
        pinMeta_reg <= {chipEnN, cmdSelN, writeN, dqIn};
        pinSync_reg <= pinMeta_reg;
        enPrev_reg <= srst ? 1'b1 : pinSync_reg[18];
    end

    logic enS, cmdS, wrS;
    logic [15:0] dqS;
    assign enS = pinSync_reg[18];
    assign cmdS = pinSync_reg[17];
    assign wrS = pinSync_reg[16];
    assign dqS = pinSync_reg[15:0];

    logic cycStart, cmdWr, cmdRd, datWr, datRd;
    assign cycStart = enPrev_reg && !enS;
    assign cmdWr = cycStart && !cmdS && !wrS;
    assign cmdRd = cycStart && !cmdS && wrS;
    assign datWr = cycStart && cmdS && !wrS;
    assign datRd = cycStart && cmdS && wrS;

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode.

    logic argPend_reg;
    logic [3:0] argTgt_reg;
    logic [7:0] opc;
    logic [3:0] opArg;
    logic instr, ctlWr, segWr, softRst, rstAll;
    assign opc = dqS[15:8];
    assign opArg = dqS[3:0];
    assign instr = cmdWr && !argPend_reg;
    assign ctlWr = cmdWr && argPend_reg && argTgt_reg == ccsr_pkg::TGT_CTL;
    assign segWr = cmdWr && argPend_reg && argTgt_reg == ccsr_pkg::TGT_SEG;
    assign softRst = ctlWr && !dqS[ccsr_pkg::CTL_RST_BIT];
    assign rstAll = srst || softRst;

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            argPend_reg <= 1'b0;
            argTgt_reg <= ccsr_pkg::TGT_CMP;
        end else if (instr && opc == ccsr_pkg::OPC_SELECT) begin
            argPend_reg <= opArg == ccsr_pkg::TGT_CTL
                || opArg == ccsr_pkg::TGT_SEG;
            argTgt_reg <= opArg;
        end else if (cycStart) begin
            argPend_reg <= 1'b0;
        end
    end

    // Reserved and keep codes both leave the field as it was.
    function automatic logic [1:0] upd2(input logic [1:0] cur,
                                        input logic [1:0] req);
        upd2 = (req == ccsr_pkg::FLD_KEEP || req == ccsr_pkg::FLD_RSVD)
            ? cur : req;
    endfunction : upd2

    ////////////////////////////////////////////////////////////////////////
    // Control word.

    logic [1:0] matchFld_reg, fullFld_reg, xlateFld_reg, modeFld_reg;
    logic [1:0] maskSel_reg, step_reg;
    logic [2:0] part_reg;
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            matchFld_reg <= ccsr_pkg::RST_FLAG_DIS;
            fullFld_reg <= ccsr_pkg::RST_FLAG_DIS;
            xlateFld_reg <= 2'h0;
            part_reg <= ccsr_pkg::RST_PART;
            maskSel_reg <= ccsr_pkg::MASK_NONE;
            step_reg <= ccsr_pkg::STEP_INC;
            modeFld_reg <= 2'h0;
        end else if (ctlWr) begin
            matchFld_reg <= upd2(matchFld_reg,
                dqS[ccsr_pkg::CTL_MATCH_LSB +: 2]);
            fullFld_reg <= upd2(fullFld_reg,
                dqS[ccsr_pkg::CTL_FULL_LSB +: 2]);
            xlateFld_reg <= upd2(xlateFld_reg,
                dqS[ccsr_pkg::CTL_XLATE_LSB +: 2]);
            part_reg <= dqS[ccsr_pkg::CTL_PART_LSB +: 3];
            if (dqS[ccsr_pkg::CTL_MASK_LSB +: 2] != ccsr_pkg::FLD_KEEP) begin
                maskSel_reg <= dqS[ccsr_pkg::CTL_MASK_LSB +: 2];
            end
            if (dqS[ccsr_pkg::CTL_STEP_LSB +: 2] != ccsr_pkg::FLD_KEEP) begin
                step_reg <= dqS[ccsr_pkg::CTL_STEP_LSB +: 2];
            end
            modeFld_reg <= upd2(modeFld_reg,
                dqS[ccsr_pkg::CTL_MODE_LSB +: 2]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment control: limits and counters for 16-bit data cycles.

    logic [1:0] dStart_reg, dEnd_reg, sStart_reg, sEnd_reg;
    logic [1:0] dCnt_reg, sCnt_reg;
    logic [3:0] dataTgt_reg;
    logic [63:0] cmp_reg, mask1_reg, mask2_reg;
    logic dLast, scanGo;
    assign dLast = dCnt_reg == dEnd_reg;

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            dStart_reg <= ccsr_pkg::RST_SEG_START;
            dEnd_reg <= ccsr_pkg::RST_SEG_END;
        end else if (segWr && !dqS[ccsr_pkg::SEG_DLIM_STB]) begin
            dStart_reg <= dqS[ccsr_pkg::SEG_DSTART_LSB +: 2];
            dEnd_reg <= dqS[ccsr_pkg::SEG_DEND_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            sStart_reg <= ccsr_pkg::RST_SEG_START;
            sEnd_reg <= ccsr_pkg::RST_SEG_END;
        end else if (segWr && !dqS[ccsr_pkg::SEG_SLIM_STB]) begin
            sStart_reg <= dqS[ccsr_pkg::SEG_SSTART_LSB +: 2];
            sEnd_reg <= dqS[ccsr_pkg::SEG_SEND_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            dCnt_reg <= ccsr_pkg::RST_SEG_START;
        end else if (segWr && !dqS[ccsr_pkg::SEG_DCNT_STB]) begin
            dCnt_reg <= dqS[ccsr_pkg::SEG_DCNT_LSB +: 2];
        end else if (datWr) begin
            dCnt_reg <= dLast ? dStart_reg : dCnt_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            sCnt_reg <= ccsr_pkg::RST_SEG_START;
        end else if (segWr && !dqS[ccsr_pkg::SEG_SCNT_STB]) begin
            sCnt_reg <= dqS[ccsr_pkg::SEG_SCNT_LSB +: 2];
        end else if (datRd) begin
            sCnt_reg <= sCnt_reg == sEnd_reg ? sStart_reg : sCnt_reg + 2'h1;
        end
    end

    // Data cycles land in the comparand unless a mask was selected.
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            dataTgt_reg <= ccsr_pkg::TGT_CMP;
            cmp_reg <= 64'h0;
            mask1_reg <= 64'h0;
            mask2_reg <= 64'h0;
        end else begin
            if (instr && opc == ccsr_pkg::OPC_SELECT && (opArg ==
                ccsr_pkg::TGT_MASK1 || opArg == ccsr_pkg::TGT_MASK2
                || opArg == ccsr_pkg::TGT_CMP)) begin
                dataTgt_reg <= opArg;
            end
            if (datWr) begin
                unique case (dataTgt_reg)
                    ccsr_pkg::TGT_MASK1: mask1_reg[dCnt_reg*16 +: 16] <= dqS;
                    ccsr_pkg::TGT_MASK2: mask2_reg[dCnt_reg*16 +: 16] <= dqS;
                    default: cmp_reg[dCnt_reg*16 +: 16] <= dqS;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory, pointer and compare scan.

    logic [AW-1:0] ptr_reg, scanAddr_reg, evalAddr_reg;
    logic [AW-1:0] hitAddr_reg, freeAddr_reg;
    logic hit_reg, multi_reg, freeSeen_reg, evalValid_reg;
    logic [1:0] hitVb_reg;
    logic [3:0] psrc_reg;
    ccsr_pkg::ccsr_scan_t scan_reg;
    logic busy, memStore, memSetVb;
    logic [63:0] rdData;
    logic [1:0] rdVb;
    assign busy = scan_reg != ccsr_pkg::SCAN_IDLE;
    assign memStore = instr && opc == ccsr_pkg::OPC_STORE && !busy
        && freeSeen_reg;
    assign memSetVb = instr && opc == ccsr_pkg::OPC_SETVB && !busy;
    assign scanGo = !busy && (memStore || memSetVb
        || (instr && opc == ccsr_pkg::OPC_COMPARE)
        || (datWr && dLast && dataTgt_reg == ccsr_pkg::TGT_CMP));

    ccsr_word_mem #(.DW(64), .DEPTH(DEPTH), .AW(AW)) wordMem (
        .core_clk(core_clk),
        .wrAddr(memStore ? freeAddr_reg : ptr_reg),
        .wrDataEn(memStore),
        .wrData(cmp_reg),
        .wrVbEn(memStore || memSetVb),
        .wrVb(memStore ? ccsr_pkg::VB_VALID : opArg[1:0]),
        .rdAddr(scanAddr_reg),
        .rdData(rdData),
        .rdVb(rdVb)
    );

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            ptr_reg <= '0;
        end else if (memSetVb) begin
            unique case (step_reg)
                ccsr_pkg::STEP_INC: ptr_reg <= ptr_reg + 1'b1;
                ccsr_pkg::STEP_DEC: ptr_reg <= ptr_reg - 1'b1;
                default: ptr_reg <= ptr_reg;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            psrc_reg <= ccsr_pkg::RST_PSRC;
        end else if (instr && opc == ccsr_pkg::OPC_SETPS) begin
            psrc_reg <= opArg;
        end
    end

    // Care mask: CAM segments of the split, minus the selected mask bits.
    logic [3:0] camSeg;
    logic [63:0] selMask, careMask;
    always_comb begin
        unique case (part_reg)
            3'h0: camSeg = 4'hf;
            3'h1: camSeg = 4'he;
            3'h2: camSeg = 4'hc;
            3'h3: camSeg = 4'h8;
            3'h4: camSeg = 4'h1;
            3'h5: camSeg = 4'h3;
            3'h6: camSeg = 4'h7;
            3'h7: camSeg = 4'hf;
        endcase
    end
    assign selMask = maskSel_reg == ccsr_pkg::MASK_FIRST ? mask1_reg
        : maskSel_reg == ccsr_pkg::MASK_SECOND ? mask2_reg : 64'h0;
    for (genvar g = 0; g < 4; g++) begin : gCare
        assign careMask[g*16 +: 16] = {16{camSeg[g]}}
            & ~selMask[g*16 +: 16];
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            scan_reg <= ccsr_pkg::SCAN_LAST;
            scanAddr_reg <= '0;
        end else begin
            unique case (scan_reg)
                ccsr_pkg::SCAN_IDLE: if (scanGo) begin
                    scan_reg <= ccsr_pkg::SCAN_RUN;
                end
                ccsr_pkg::SCAN_RUN: begin
                    scanAddr_reg <= scanAddr_reg + 1'b1;
                    if (scanAddr_reg == AW'(DEPTH - 1)) begin
                        scan_reg <= ccsr_pkg::SCAN_LAST;
                    end
                end
                ccsr_pkg::SCAN_LAST: scan_reg <= ccsr_pkg::SCAN_IDLE;
            endcase
        end
    end

    logic hitNow;
    assign hitNow = rdVb == ccsr_pkg::VB_VALID
        && ((rdData ^ cmp_reg) & careMask) == 64'h0;

    always_ff @(posedge core_clk) begin
        evalValid_reg <= !rstAll && scan_reg == ccsr_pkg::SCAN_RUN;
        evalAddr_reg <= scanAddr_reg;
        if (rstAll || scanGo) begin
            hit_reg <= 1'b0;
            multi_reg <= 1'b0;
            freeSeen_reg <= !scanGo;
            freeAddr_reg <= '0;
            hitAddr_reg <= '0;
            hitVb_reg <= ccsr_pkg::VB_EMPTY;
        end else if (evalValid_reg) begin
            if (hitNow && !hit_reg) begin
                hit_reg <= 1'b1;
                hitAddr_reg <= evalAddr_reg;
                hitVb_reg <= rdVb;
            end
            if (hitNow && hit_reg) begin
                multi_reg <= 1'b1;
            end
            if (rdVb == ccsr_pkg::VB_EMPTY && !freeSeen_reg) begin
                freeSeen_reg <= 1'b1;
                freeAddr_reg <= evalAddr_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-only words and host readout.

    logic [31:0] statusWord;
    logic [15:0] nfreeWord, idWord, ctlWord, segWord, dataWord;
    assign statusWord[31] = freeSeen_reg;
    assign statusWord[30] = !multi_reg;
    assign statusWord[29:28] = hitVb_reg;
    assign statusWord[27:0] = (28'(PAGE_NUM) << (AW + 1))
        | (28'(hitAddr_reg) << 1) | 28'(!hit_reg);
    assign nfreeWord = (PAGE_NUM << AW) | 16'(freeAddr_reg);
    assign idWord = {PART_ID, psrc_reg};
    assign ctlWord = {1'b0, matchFld_reg, fullFld_reg, xlateFld_reg,
        part_reg, maskSel_reg, step_reg, modeFld_reg};
    assign segWord = {1'b0, dStart_reg, dEnd_reg, 1'b0, sStart_reg,
        sEnd_reg, 1'b0, dCnt_reg, 1'b0, sCnt_reg};
    assign dataWord = cmp_reg[sCnt_reg*16 +: 16];

    ccsr_pkg::ccsr_rdsel_t rdSel_reg;
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            rdSel_reg <= ccsr_pkg::RD_STAT_LO;
        end else if (instr && opc == ccsr_pkg::OPC_SELECT) begin
            unique case (opArg)
                ccsr_pkg::TGT_NFREE: rdSel_reg <= ccsr_pkg::RD_NFREE;
                ccsr_pkg::TGT_IDSRC: rdSel_reg <= ccsr_pkg::RD_IDSRC;
                ccsr_pkg::TGT_CTL: rdSel_reg <= ccsr_pkg::RD_CTL;
                ccsr_pkg::TGT_SEG: rdSel_reg <= ccsr_pkg::RD_SEG;
                default: rdSel_reg <= ccsr_pkg::RD_STAT_LO;
            endcase
        end else if (cmdRd && rdSel_reg == ccsr_pkg::RD_STAT_LO) begin
            rdSel_reg <= ccsr_pkg::RD_STAT_HI;
        end else if (cycStart) begin
            rdSel_reg <= ccsr_pkg::RD_STAT_LO;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            dqOut <= 16'h0;
            dqOe <= 1'b0;
        end else begin
            if (cmdRd) begin
                unique case (rdSel_reg)
                    ccsr_pkg::RD_STAT_LO: dqOut <= statusWord[15:0];
                    ccsr_pkg::RD_STAT_HI: dqOut <= statusWord[31:16];
                    ccsr_pkg::RD_NFREE: dqOut <= nfreeWord;
                    ccsr_pkg::RD_IDSRC: dqOut <= idWord;
                    ccsr_pkg::RD_CTL: dqOut <= ctlWord;
                    ccsr_pkg::RD_SEG: dqOut <= segWord;
                    default: dqOut <= statusWord[15:0];
                endcase
            end else if (datRd) begin
                dqOut <= dataWord;
            end
            dqOe <= enS ? 1'b0 : (dqOe || ((cmdRd || datRd) && wrS));
        end
    end

    // Disabled flags idle high, the inactive level of these pins.
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            matchFlagN <= 1'b1;
            multiMatchFlagN <= 1'b1;
            fullFlagN <= 1'b1;
            translateOn <= 1'b0;
            enhancedMode <= 1'b0;
        end else begin
            matchFlagN <= matchFld_reg[0] || !hit_reg;
            multiMatchFlagN <= matchFld_reg[0] || !multi_reg;
            fullFlagN <= fullFld_reg[0] || freeSeen_reg;
            translateOn <= xlateFld_reg[0];
            enhancedMode <= modeFld_reg[0];
        end
    end

endmodule : ccsr_regs

// ---- testbench/ccsr_regs_monitor.sv ----
module ccsr_regs_monitor (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chipEnN,
    input wire logic cmdSelN,
    input wire logic writeN,
    input wire logic [15:0] dqIn,
    input wire logic [15:0] dqOut,
    input wire logic dqOe,
    input wire logic matchFlagN,
    input wire logic multiMatchFlagN,
    input wire logic fullFlagN,
    input wire logic translateOn,
    input wire logic enhancedMode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    property p_rst_idle;
        $fell(srst) |-> !dqOe && dqOut == 16'h0000 && matchFlagN &&
            multiMatchFlagN && fullFlagN && !translateOn && !enhancedMode;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs not idle after reset");
    property p_oe_read;
        dqOe |-> writeN;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("data driven on a write cycle");
    property p_oe_answer;
        $fell(chipEnN) && writeN |-> ##[2:6] dqOe;
    endproperty
    a_oe_answer: assert property (p_oe_answer)
        else $error("read cycle got no answer");
    property p_oe_cause;
        $rose(dqOe) |-> !chipEnN && !$past(chipEnN, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("data driven without enable");
    property p_oe_release;
        $rose(chipEnN) |-> ##[1:5] !dqOe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("bus not released after cycle");
    property p_oe_idle;
        chipEnN [*5] |-> !dqOe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("bus driven while idle");
    property p_mode_src;
        $changed(translateOn) || $changed(enhancedMode) |->
            !cmdSelN && !writeN;
    endproperty
    a_mode_src: assert property (p_mode_src)
        else $error("mode changed outside a command write");
    property p_multi_match;
        !multiMatchFlagN |-> !matchFlagN;
    endproperty
    a_multi_match: assert property (p_multi_match)
        else $error("multiple match without match");
endmodule : ccsr_regs_monitor
bind ccsr_regs ccsr_regs_monitor u_ccsr_regs_monitor (.core_clk, .srst,
    .chipEnN, .cmdSelN, .writeN, .dqIn, .dqOut, .dqOe, .matchFlagN,
    .multiMatchFlagN, .fullFlagN, .translateOn, .enhancedMode);

// ---- testbench/ccsr_host_model.sv ----
module ccsr_host_model (
    input wire logic core_clk,
    output logic chipEnN,
    output logic cmdSelN,
    output logic writeN,
    output logic [15:0] dqIn,
    input wire logic [15:0] dqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chipEnN = 1'b1;
        cmdSelN = 1'b1;
        writeN = 1'b1;
        dqIn = 16'h0000;
    end
    // Pins settle one edge before enable and hold past the sync delay.
    // On reads the lines flip so a stale value never looks driven.
    task cyc(input logic c, input logic w, input logic [15:0] d,
        output logic [15:0] q);
        cmdSelN <= ~c;
        writeN <= ~w;
        dqIn <= w ? d : ~dqIn;
        @(posedge core_clk);
        chipEnN <= 1'b0;
        repeat (6) @(posedge core_clk);
        q = dqOut;
        chipEnN <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask : cyc
endmodule : ccsr_host_model

// ---- testbench/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic chipEnN, cmdSelN, writeN, dqOe, matchFlagN, multiMatchFlagN;
    logic fullFlagN, translateOn, enhancedMode;
    logic [15:0] dqIn, dqOut, rd;
    logic [15:0] segW [7] = '{16'h0000, 16'h3311, 16'hffff, 16'h7fff,
        16'hfbff, 16'hffdf, 16'hfffb};
    logic [15:0] segE [7] = '{16'h0000, 16'h3311, 16'h3311, 16'h7b11,
        16'h7bd1, 16'h7bd9, 16'h7bdb};
    int errTotal = 0;
    int numChecks = 0;
    always #10 core_clk = ~core_clk;
    // Identity value is arbitrary.
    ccsr_regs #(.DEPTH(16), .PAGE_NUM(16'h0abc), .PART_ID(12'h3c7))
        u_ccsr_regs (.core_clk, .srst, .chipEnN, .cmdSelN, .writeN, .dqIn,
        .dqOut, .dqOe, .matchFlagN, .multiMatchFlagN, .fullFlagN,
        .translateOn, .enhancedMode);
    ccsr_host_model u_ccsr_host_model (.core_clk, .chipEnN, .cmdSelN,
        .writeN, .dqIn, .dqOut);
    ////////////////////////////////////////////////////////////
    function logic [15:0] pins();
        return {11'h000, matchFlagN, multiMatchFlagN, fullFlagN,
            translateOn, enhancedMode};
    endfunction : pins
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task cw(input logic [15:0] d);
        u_ccsr_host_model.cyc(1'b1, 1'b1, d, rd);
    endtask : cw
    task cr();
        u_ccsr_host_model.cyc(1'b1, 1'b0, 16'h0000, rd);
    endtask : cr
    task sel(input logic [3:0] t);
        cw({ccsr_pkg::OPC_SELECT, 4'h0, t});
    endtask : sel
    task rdreg(input logic [3:0] t, input string n, input logic [15:0] e);
        sel(t);
        cr();
        chk(n, e, rd);
    endtask : rdreg
    task wctl(input logic [15:0] d, input logic [15:0] e);
        sel(ccsr_pkg::TGT_CTL);
        cw(d);
        rdreg(ccsr_pkg::TGT_CTL, "control", e);
    endtask : wctl
    task waitScan();
        repeat (30) @(posedge core_clk);
    endtask : waitScan
    // Scan-starting instructions are refused while a scan runs.
    task op(input logic [15:0] d);
        cw(d);
        waitScan();
    endtask : op
    task endSim();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : endSim
    ////////////////////////////////////////////////////////////
    task t_reset();
        chk("pins", 16'h001c, pins());
        rdreg(ccsr_pkg::TGT_CTL, "control", 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task t_ctl();
        wctl(16'hab65, 16'h2b65);
        chk("pins", 16'h001f, pins());
        wctl(16'hffff, 16'h2be5);
        wctl(16'hd57e, 16'h2b65);
        wctl(16'h7fff, 16'h0000);
        chk("pins", 16'h001c, pins());
        wctl(16'h80d8, 16'h00d8);
        for (int i = 0; i < 8; i++) begin
            wctl(16'hfe3f | 16'(i << 6), 16'h0018 | 16'(i << 6));
        end
        wctl(16'h0000, 16'h0000);
        $display("test control done");
    endtask : t_ctl
    task t_ro();
        repeat (16) op({ccsr_pkg::OPC_SETVB, 6'h00, ccsr_pkg::VB_EMPTY});
        op({ccsr_pkg::OPC_COMPARE, 8'h00});
        rdreg(ccsr_pkg::TGT_NFREE, "next free", 16'habc0);
        for (int i = 1; i < 5; i++) begin
            u_ccsr_host_model.cyc(1'b0, 1'b1, 16'(i * 16'h1111), rd);
        end
        waitScan();
        op({ccsr_pkg::OPC_STORE, 8'h00});
        op({ccsr_pkg::OPC_COMPARE, 8'h00});
        chk("pins", 16'h000c, pins());
        rdreg(ccsr_pkg::TGT_STATUS, "status low", 16'h5780);
        cr();
        chk("status high", 16'hc001, rd);
        rdreg(ccsr_pkg::TGT_NFREE, "next free", 16'habc1);
        op({ccsr_pkg::OPC_STORE, 8'h00});
        op({ccsr_pkg::OPC_COMPARE, 8'h00});
        chk("pins", 16'h0004, pins());
        rdreg(ccsr_pkg::TGT_STATUS, "status low", 16'h5780);
        cr();
        chk("status high", 16'h8001, rd);
        // With the low segment as RAM, a changed low segment still matches.
        wctl(16'hfe7f, 16'h0040);
        u_ccsr_host_model.cyc(1'b0, 1'b1, 16'h0bad, rd);
        op({ccsr_pkg::OPC_COMPARE, 8'h00});
        chk("pins", 16'h0004, pins());
        u_ccsr_host_model.cyc(1'b0, 1'b0, 16'h0000, rd);
        chk("data read", 16'h0bad, rd);
        cw({ccsr_pkg::OPC_SETPS, 8'h05});
        rdreg(ccsr_pkg::TGT_IDSRC, "identity", 16'h3c75);
        $display("test read only done");
    endtask : t_ro
    task t_seg();
        for (int i = 0; i < 7; i++) begin
            sel(ccsr_pkg::TGT_SEG);
            cw(segW[i]);
            rdreg(ccsr_pkg::TGT_SEG, "segment", segE[i]);
        end
        $display("test segment done");
    endtask : t_seg
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        errTotal++;
        endSim();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_ctl();
        t_ro();
        t_seg();
        endSim();
    end
endmodule : tb_top
